/* design/ifb_pkg.sv */
// Package: register map, timing constants and types of the ISP flash access block
package ifb_pkg;
  // Register byte offsets on the Avalon-MM slave
  localparam logic [4:0]  OFF_ADDR_HIGH     = 5'h00;
  localparam logic [4:0]  OFF_ADDR_LOW      = 5'h04;
  localparam logic [4:0]  OFF_READ_DATA     = 5'h08;
  localparam logic [4:0]  OFF_WRITE_DATA    = 5'h0C;
  localparam logic [4:0]  OFF_PULSE_TIMING  = 5'h10;
  localparam logic [4:0]  OFF_SEQ_CTRL      = 5'h14;
  localparam logic [4:0]  OFF_STATUS        = 5'h18;

  // Reset values
  localparam logic [7:0]  RST_ADDR          = 8'h00;
  localparam logic [7:0]  RST_WRITE_DATA    = 8'h00;
  localparam logic [7:0]  RST_READ_DATA     = 8'h00;
  localparam logic [7:0]  RST_PULSE_TIMING  = 8'h7B;   // 7.5 MHz to 10 MHz setting

  // Field positions
  localparam int          CMD_LSB           = 0;
  localparam int          STAT_BUSY_BIT     = 0;
  localparam int          STAT_BOOT_BIT     = 1;
  localparam int          STAT_ROM_EXEC_BIT = 2;

  // Special flash addresses
  localparam logic [15:0] ADDR_MASS         = 16'h0000;
  localparam logic [15:0] ADDR_OPTION_ALIAS = 16'hFFFF;
  localparam logic [15:0] ADDR_OPTION       = 16'h3FFF;

  // Boot ROM geometry
  localparam int          ROM_BYTES         = 1024;
  localparam int          ROM_AW            = 10;

  // Timing
  localparam int          CLK_PERIOD_NS     = 4;
  localparam int          READ_ACCESS_NS    = 28;
  localparam int          READ_CYCLES       = (READ_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int          PULSE_UNIT_NS     = 1000;
  localparam int          PULSE_UNIT_CYCLES = (PULSE_UNIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  typedef enum logic [1:0] {
    CMD_NONE  = 2'b00,
    CMD_READ  = 2'b01,
    CMD_WRITE = 2'b10,
    CMD_ERASE = 2'b11
  } ifb_cmd_type;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_READ  = 2'b01,
    ST_PULSE = 2'b10
  } ifb_state_type;

  // Request to the flash array macro
  typedef struct packed {
    logic [15:0] addr;
    logic [7:0]  wdata;
    logic        rd;
    logic        prog;
    logic        erase;
    logic        mass;
  } ifb_flash_req_type;
endpackage : ifb_pkg

/* design/ifb_boot_rom.sv */
// Factory boot ROM, 1k bytes, one registered read port
`timescale 1ns/1ps
module ifb_boot_rom
  import ifb_pkg::*;
#(
  parameter logic [ROM_BYTES*8-1:0] ROM_IMAGE = '0   // Factory image, byte 0 lowest
) (
  input  wire logic              clk_sys_i,   // System clock
  input  wire logic              arst_n_i,    // Async reset, active low
  input  wire logic [ROM_AW-1:0] rom_addr_i,  // Fetch byte address
  output logic      [7:0]        rom_data_o   // Fetched byte, one cycle later
);
  logic [7:0] mem [ROM_BYTES];
  logic [7:0] next_rom_data;

  // Unpack image into the byte array
  always_comb begin
    for (int i = 0; i < ROM_BYTES; i++) begin
      mem[i] = ROM_IMAGE[i*8 +: 8];
    end
  end

  // Read mux
  always_comb begin
    next_rom_data = mem[rom_addr_i];
  end

  // Registered data for timing closure
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rom_data_o <= 8'h00;
    end else begin
      rom_data_o <= next_rom_data;
    end
  end

  // ROM fetch latency
  // Only loads made out of reset count, the release edge still leaves zero behind
  rom_fetch_a: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
    $past(arst_n_i) |-> rom_data_o == mem[$past(rom_addr_i)])
    else $error("boot ROM byte does not match address of previous cycle");
endmodule : ifb_boot_rom

/* design/ifb_isp_flash_access.sv */
// ISP flash access: boot source selection, ISP registers and flash sequencer
//
// Added by the designer: the Avalon-MM interface to the registers and the register offsets.
`timescale 1ns/1ps
module ifb_isp_flash_access
  import ifb_pkg::*;
#(
  parameter int unsigned            PULSE_UNIT = PULSE_UNIT_CYCLES,  // Cycles per timing step
  parameter logic [ROM_BYTES*8-1:0] ROM_IMAGE  = '0                  // Boot ROM contents
) (
  input  wire logic              clk_sys_i,            // System clock, 250 MHz
  input  wire logic              arst_n_i,             // Async reset, active low
  input  wire logic [4:0]        avs_address_i,        // Avalon byte address
  input  wire logic              avs_read_i,           // Avalon read
  input  wire logic              avs_write_i,          // Avalon write
  input  wire logic [31:0]       avs_writedata_i,      // Avalon write data
  input  wire logic [3:0]        avs_byteenable_i,     // Avalon byte enables
  output logic      [31:0]       avs_readdata_o,       // Avalon read data
  output logic                   avs_waitrequest_o,    // Avalon wait request
  input  wire logic              boot_source_select_i, // Option bit, from outside domain
  input  wire logic              rom_exec_i,           // Core now runs from boot ROM
  output logic                   boot_from_rom_o,      // Reset fetch source is ROM
  output logic                   core_release_o,       // Boot source valid, core may run
  output logic                   serial_cmd_watch_o,   // Serial command watch enable
  input  wire logic [ROM_AW-1:0] rom_fetch_addr_i,     // Boot ROM fetch address
  output logic      [7:0]        rom_fetch_data_o,     // Boot ROM fetch data
  output ifb_flash_req_type      flash_req_o,          // Request to flash array
  input  wire logic [7:0]        flash_rdata_i         // Flash array read byte
);
  // Boot selection state
  logic       opt_meta, opt_sync;
  logic [1:0] sync_fill;
  logic       captured, next_captured, next_boot_rom, next_watch;

  // Register and bus state
  logic [7:0]  addr_high, addr_low, write_data, pulse_timing;
  logic [7:0]  next_addr_high, next_addr_low, next_write_data, next_pulse_timing;
  logic [31:0] next_readdata;
  logic        rd_ack, next_rd_ack;
  logic        stall, wr_take, start;
  ifb_cmd_type cmd;

  // Sequencer state
  ifb_state_type     state, next_state;
  ifb_flash_req_type next_req;
  logic [19:0]       cnt, next_cnt, pulse_total;
  logic [7:0]        read_data, next_read_data;
  logic [15:0]       isp_addr;
  logic              busy;

  // Two-stage synchroniser and fill marker for the option bit
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      opt_meta  <= 1'b0;
      opt_sync  <= 1'b0;
      sync_fill <= 2'b00;
    end else begin
      opt_meta  <= boot_source_select_i;
      opt_sync  <= opt_meta;
      sync_fill <= {sync_fill[0], 1'b1};
    end
  end

  // Boot source is taken once per reset, so a changed bit waits for the next reset
  always_comb begin
    next_captured = captured;
    next_boot_rom = boot_from_rom_o;
    next_watch    = rom_exec_i & captured;
    if (!captured && sync_fill[1]) begin
      next_captured = 1'b1;
      next_boot_rom = ~opt_sync;
    end
  end

  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      captured           <= 1'b0;
      boot_from_rom_o    <= 1'b1;   // Safe default is the loader
      serial_cmd_watch_o <= 1'b0;
    end else begin
      captured           <= next_captured;
      boot_from_rom_o    <= next_boot_rom;
      serial_cmd_watch_o <= next_watch;
    end
  end

  assign core_release_o = captured;

  // Bus handshake: reads take one wait cycle so read data comes from a flop
  always_comb begin
    busy  = (state != ST_IDLE);
    stall = busy & ((avs_read_i & (avs_address_i == OFF_READ_DATA)) |
                    (avs_write_i & (avs_address_i == OFF_SEQ_CTRL)));
    avs_waitrequest_o = stall | (avs_read_i & ~rd_ack);
    wr_take = avs_write_i & ~stall & avs_byteenable_i[0];
    cmd     = ifb_cmd_type'(avs_writedata_i[CMD_LSB +: 2]);
    start   = wr_take & (avs_address_i == OFF_SEQ_CTRL) & rom_exec_i & (cmd != CMD_NONE);
  end

  // Register writes and read mux
  always_comb begin
    next_addr_high    = addr_high;
    next_addr_low     = addr_low;
    next_write_data   = write_data;
    next_pulse_timing = pulse_timing;
    next_readdata     = avs_readdata_o;
    next_rd_ack       = 1'b0;
    if (wr_take) begin
      case (avs_address_i)
        OFF_ADDR_HIGH:    next_addr_high    = avs_writedata_i[7:0];
        OFF_ADDR_LOW:     next_addr_low     = avs_writedata_i[7:0];
        OFF_WRITE_DATA:   next_write_data   = avs_writedata_i[7:0];
        OFF_PULSE_TIMING: next_pulse_timing = avs_writedata_i[7:0];
        default:          next_addr_high    = addr_high;
      endcase
    end
    if (avs_read_i && !rd_ack && !stall) begin
      next_rd_ack = 1'b1;
      case (avs_address_i)
        OFF_ADDR_HIGH:    next_readdata = {24'h000000, addr_high};
        OFF_ADDR_LOW:     next_readdata = {24'h000000, addr_low};
        OFF_READ_DATA:    next_readdata = {24'h000000, read_data};
        OFF_WRITE_DATA:   next_readdata = {24'h000000, write_data};
        OFF_PULSE_TIMING: next_readdata = {24'h000000, pulse_timing};
        OFF_STATUS:       next_readdata = {29'h00000000, rom_exec_i, boot_from_rom_o, busy};
        default:          next_readdata = 32'h00000000;   // Control and holes read zero
      endcase
    end
  end

  // timing resets to 10 MHz value
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      addr_high      <= RST_ADDR;
      addr_low       <= RST_ADDR;
      write_data     <= RST_WRITE_DATA;
      pulse_timing   <= RST_PULSE_TIMING;
      avs_readdata_o <= 32'h00000000;
      rd_ack         <= 1'b0;
    end else begin
      addr_high      <= next_addr_high;
      addr_low       <= next_addr_low;
      write_data     <= next_write_data;
      pulse_timing   <= next_pulse_timing;
      avs_readdata_o <= next_readdata;
      rd_ack         <= next_rd_ack;
    end
  end

  // Sequencer: latches address, data and command at start; pulse length follows pulse_timing live, so writes to it change a running pulse
  always_comb begin
    isp_addr    = {addr_high, addr_low};
    // Zero timing still gives one step, never a zero pulse
    pulse_total = 20'(pulse_timing == 8'h00 ? 8'h01 : pulse_timing) * 20'(PULSE_UNIT);
    next_state     = state;
    next_req       = flash_req_o;
    next_cnt       = cnt + 20'h00001;
    next_read_data = read_data;
    case (state)
      ST_IDLE: begin
        next_cnt = 20'h00000;
        if (start) begin
          next_req.addr  = isp_addr;
          next_req.wdata = write_data;
          next_req.rd    = (cmd == CMD_READ);
          next_req.prog  = (cmd == CMD_WRITE);
          next_req.erase = (cmd == CMD_ERASE);
          next_req.mass  = (cmd == CMD_ERASE) && (isp_addr == ADDR_MASS);
          // option alias maps to real location
          if (cmd == CMD_READ && isp_addr == ADDR_OPTION_ALIAS) begin
            next_req.addr = ADDR_OPTION;
          end
          next_state = (cmd == CMD_READ) ? ST_READ : ST_PULSE;
        end
      end
      ST_READ: begin
        if (cnt == 20'(READ_CYCLES - 1)) begin
          next_read_data = flash_rdata_i;
          next_req.rd    = 1'b0;
          next_state     = ST_IDLE;
        end
      end
      ST_PULSE: begin
        // finish pulse before next access
        // Not equality, so a timing value lowered mid pulse cannot hang the sequencer
        if (next_cnt >= pulse_total) begin
          next_req.prog  = 1'b0;
          next_req.erase = 1'b0;
          next_req.mass  = 1'b0;
          next_state     = ST_IDLE;
        end
      end
      default: begin
        next_state = ST_IDLE;
        next_req   = '0;
      end
    endcase
  end

  // Sequencer registers
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      state       <= ST_IDLE;
      flash_req_o <= '0;
      cnt         <= 20'h00000;
      read_data   <= RST_READ_DATA;
    end else begin
      state       <= next_state;
      flash_req_o <= next_req;
      cnt         <= next_cnt;
      read_data   <= next_read_data;
    end
  end

  ifb_boot_rom #(
    .ROM_IMAGE (ROM_IMAGE)
  ) u_boot_rom (
    .clk_sys_i  (clk_sys_i),
    .arst_n_i   (arst_n_i),
    .rom_addr_i (rom_fetch_addr_i),
    .rom_data_o (rom_fetch_data_o)
  );

  // Pulse length checker: counts cycles the write or erase strobe stays high
  logic [19:0] chk_len;
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      chk_len <= 20'h00000;
    end else begin
      chk_len <= (flash_req_o.prog | flash_req_o.erase) ? chk_len + 20'h00001 : 20'h00000;
    end
  end

  sequence read_begin_s;
    start && cmd == CMD_READ;
  endsequence
  sequence read_strobe_s;
    flash_req_o.rd [*7] ##1 !flash_req_o.rd;
  endsequence

  boot_rom_sel_a: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
    $rose(captured) && !$past(opt_sync) |-> boot_from_rom_o)
    else $error("erased boot bit did not select ROM");
  boot_flash_sel_a: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
    $rose(captured) && $past(opt_sync) |-> !boot_from_rom_o ##1 !boot_from_rom_o)
    else $error("set boot bit did not select flash");
  addr_form_a: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
    start && cmd != CMD_READ |=> flash_req_o.addr == $past({addr_high, addr_low}))
    else $error("flash address not formed from high and low registers");
  addr_reset_a: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
    $rose(sync_fill[0]) && !$past(avs_write_i) |-> addr_high == 8'h00 && addr_low == 8'h00)
    else $error("address registers not cleared by reset");
  read_capture_a: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
    read_begin_s |=> read_strobe_s ##0 read_data == $past(flash_rdata_i))
    else $error("read strobe length or captured byte wrong");
  ctrl_lock_a: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
    avs_write_i && avs_address_i == OFF_SEQ_CTRL && !rom_exec_i && !busy |=> !busy)
    else $error("user code started a flash operation");
  serial_watch_a: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
    captured && rom_exec_i |=> serial_cmd_watch_o)
    else $error("serial command watch off while running ROM");
  busy_stall_a: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
    busy && avs_read_i && avs_address_i == OFF_READ_DATA |-> avs_waitrequest_o)
    else $error("read data returned during flash operation");
  pulse_len_a: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
    $fell(flash_req_o.prog | flash_req_o.erase) |-> $past(chk_len) + 20'h00001 ==
      20'($past(pulse_timing) == 8'h00 ? 8'h01 : $past(pulse_timing)) * 20'(PULSE_UNIT))
    else $error("program or erase pulse length does not match timing register");
endmodule : ifb_isp_flash_access

/* verification/ifb_isp_flash_access_tb.sv */
// Testbench: Avalon register access, flash sequencing and boot source of the ISP block
`timescale 1ns/1ps
module ifb_isp_flash_access_tb
  import ifb_pkg::*;
;
  localparam int LIMIT = 20000;  // Whole run needs about 150 cycles

  // Byte from the low eight address bits, distinct within each 256 bytes, so a wrong low fetch index shows up
  function automatic logic [ROM_BYTES*8-1:0] make_img();
    logic [ROM_BYTES*8-1:0] img;
    img = '0;
    for (int k = 0; k < ROM_BYTES; k++) begin
      img[k*8 +: 8] = k[7:0] ^ 8'h5A;
    end
    return img;
  endfunction : make_img

  localparam logic [ROM_BYTES*8-1:0] IMG = make_img();

  logic              clk_sys_i;
  logic              arst_n_i;
  logic [4:0]        avs_address_i;
  logic              avs_read_i;
  logic              avs_write_i;
  logic [31:0]       avs_writedata_i;
  logic [31:0]       avs_readdata_o;
  logic              avs_waitrequest_o;
  logic              boot_source_select_i;
  logic              rom_exec_i;
  logic              boot_from_rom_o;
  logic              core_release_o;
  logic              serial_cmd_watch_o;
  logic [ROM_AW-1:0] rom_fetch_addr_i;
  logic [7:0]        rom_fetch_data_o;
  ifb_flash_req_type flash_req_o;
  logic [7:0]        flash_rdata_i;
  ifb_flash_req_type seen_req;
  logic [31:0]       rd_val;
  logic              op_at_answer;
  int                bad_count;
  int                checked;
  int                cyc;
  int                run;
  int                run_len;

  ifb_isp_flash_access #(.PULSE_UNIT(2), .ROM_IMAGE(IMG)) u_dut (
    .clk_sys_i            (clk_sys_i),
    .arst_n_i             (arst_n_i),
    .avs_address_i        (avs_address_i),
    .avs_read_i           (avs_read_i),
    .avs_write_i          (avs_write_i),
    .avs_writedata_i      (avs_writedata_i),
    .avs_byteenable_i     (4'hF),
    .avs_readdata_o       (avs_readdata_o),
    .avs_waitrequest_o    (avs_waitrequest_o),
    .boot_source_select_i (boot_source_select_i),
    .rom_exec_i           (rom_exec_i),
    .boot_from_rom_o      (boot_from_rom_o),
    .core_release_o       (core_release_o),
    .serial_cmd_watch_o   (serial_cmd_watch_o),
    .rom_fetch_addr_i     (rom_fetch_addr_i),
    .rom_fetch_data_o     (rom_fetch_data_o),
    .flash_req_o          (flash_req_o),
    .flash_rdata_i        (flash_rdata_i)
  );

  // Clock, 4 ns period
  initial begin
    clk_sys_i = 1'b0;
    forever #2 clk_sys_i = ~clk_sys_i;
  end

  // Cycle ceiling; a hang ends here as a mismatch
  always @(posedge clk_sys_i) begin
    cyc++;
    if (cyc == LIMIT) begin
      bad_count++;
      end_of_test();
    end
  end

  // Strobe length and first-cycle request capture
  always @(posedge clk_sys_i) begin
    if (flash_req_o.rd | flash_req_o.prog | flash_req_o.erase) begin
      if (run == 0) seen_req = flash_req_o;
      run++;
    end else if (run != 0) begin
      run_len = run;
      run = 0;
    end
  end

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      $display("unexpected %s expected %h seen %h", n, e, g);
      bad_count++;
    end
  endtask : chk

  // Request held until waitrequest is sampled low at a rising edge
  task automatic bus_write(input logic [4:0] a, input logic [7:0] d);
    @(posedge clk_sys_i);
    avs_address_i   <= a;
    avs_writedata_i <= {24'h000000, d};
    avs_write_i     <= 1'b1;
    do @(posedge clk_sys_i); while (avs_waitrequest_o !== 1'b0);
    avs_write_i     <= 1'b0;
  endtask : bus_write

  task automatic bus_read(input logic [4:0] a, output logic [31:0] d);
    @(posedge clk_sys_i);
    avs_address_i <= a;
    avs_read_i    <= 1'b1;
    do @(posedge clk_sys_i); while (avs_waitrequest_o !== 1'b0);
    d            = avs_readdata_o;
    op_at_answer = flash_req_o.prog | flash_req_o.erase | flash_req_o.rd;
    avs_read_i   <= 1'b0;
  endtask : bus_read

  task automatic reg_chk(input string n, input logic [4:0] a, input logic [7:0] e);
    bus_read(a, rd_val);
    chk(n, {24'h000000, e}, rd_val);
  endtask : reg_chk

  // Poll busy with a bound; busy stuck high gives up after 100 polls and returns
  task automatic wait_idle();
    for (int i = 0; i < 100; i++) begin
      bus_read(OFF_STATUS, rd_val);
      if (rd_val[STAT_BUSY_BIT] === 1'b0) break;
    end
  endtask : wait_idle

  task automatic do_reset(input logic sel);
    boot_source_select_i <= sel;
    arst_n_i             <= 1'b0;
    repeat (5) @(posedge clk_sys_i);
    arst_n_i             <= 1'b1;
    repeat (4) @(posedge clk_sys_i);
  endtask : do_reset

  task automatic end_of_test();
    $display("counts: checked %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : end_of_test

  initial begin
    bad_count = 0; checked = 0; cyc = 0; run = 0; run_len = 0;
    arst_n_i = 1'b0; avs_address_i = 5'h00; avs_read_i = 1'b0; avs_write_i = 1'b0;
    avs_writedata_i = 32'h00000000; boot_source_select_i = 1'b0; rom_exec_i = 1'b1;
    rom_fetch_addr_i = '0; flash_rdata_i = 8'hA5;
    do_reset(1'b0);
    // Reset values, erased option bit boots from ROM
    chk("boot_from_rom", 32'h1, {31'h0, boot_from_rom_o});
    chk("core_release", 32'h1, {31'h0, core_release_o});
    reg_chk("addr_high", OFF_ADDR_HIGH, 8'h00);
    reg_chk("addr_low", OFF_ADDR_LOW, 8'h00);
    reg_chk("pulse_timing", OFF_PULSE_TIMING, 8'h7B);
    reg_chk("unmapped", 5'h1C, 8'h00);
    reg_chk("seq_ctrl_readback", OFF_SEQ_CTRL, 8'h00);
    $display("test reset_values done");
    // Address pair and flash read, plus option byte alias
    bus_write(OFF_ADDR_HIGH, 8'h12);
    bus_write(OFF_ADDR_LOW, 8'h34);
    reg_chk("addr_high_rw", OFF_ADDR_HIGH, 8'h12);
    reg_chk("addr_low_rw", OFF_ADDR_LOW, 8'h34);
    bus_write(OFF_SEQ_CTRL, 8'h01);
    wait_idle();
    chk("read_addr", 32'h1234, {16'h0, seen_req.addr});
    chk("read_len", READ_CYCLES, run_len);
    reg_chk("read_data", OFF_READ_DATA, 8'hA5);
    flash_rdata_i <= 8'h5C;
    bus_write(OFF_ADDR_HIGH, 8'hFF);
    bus_write(OFF_ADDR_LOW, 8'hFF);
    bus_write(OFF_SEQ_CTRL, 8'h01);
    wait_idle();
    chk("option_addr", {16'h0, ADDR_OPTION}, {16'h0, seen_req.addr});
    reg_chk("option_data", OFF_READ_DATA, 8'h5C);
    $display("test flash_read done");
    // Program pulse width, page erase and mass erase with a stalled read
    bus_write(OFF_PULSE_TIMING, 8'h03);
    bus_write(OFF_WRITE_DATA, 8'h3C);
    bus_write(OFF_ADDR_HIGH, 8'h01);
    bus_write(OFF_ADDR_LOW, 8'h40);
    bus_write(OFF_SEQ_CTRL, 8'h02);
    wait_idle();
    chk("prog_flag", 32'h1, {31'h0, seen_req.prog});
    chk("prog_wdata", 32'h3C, {24'h0, seen_req.wdata});
    reg_chk("write_data_rw", OFF_WRITE_DATA, 8'h3C);
    chk("prog_len", 32'd6, run_len);
    bus_write(OFF_SEQ_CTRL, 8'h03);
    wait_idle();
    chk("page_addr", 32'h0140, {16'h0, seen_req.addr});
    chk("page_mass", 32'h0, {31'h0, seen_req.mass});
    bus_write(OFF_ADDR_HIGH, 8'h00);
    bus_write(OFF_ADDR_LOW, 8'h00);
    bus_write(OFF_SEQ_CTRL, 8'h03);
    bus_read(OFF_READ_DATA, rd_val);
    chk("read_during_erase", 32'h0, {31'h0, op_at_answer});
    chk("read_kept", 32'h5C, rd_val);
    chk("mass_flag", 32'h1, {31'h0, seen_req.mass});
    chk("erase_len", 32'd6, run_len);
    $display("test write_erase done");
    // Control from non-ROM code and command 0 have no effect
    chk("watch_on", 32'h1, {31'h0, serial_cmd_watch_o});
    run_len = 0;
    bus_write(OFF_SEQ_CTRL, 8'h00);
    // Status: ROM execution and ROM boot set, busy clear after command 0
    reg_chk("status_cmd_none", OFF_STATUS, 8'h06);
    rom_exec_i <= 1'b0;
    bus_write(OFF_SEQ_CTRL, 8'h01);
    repeat (12) @(posedge clk_sys_i);
    chk("refused_ctrl", 32'h0, run_len);
    chk("watch_off", 32'h0, {31'h0, serial_cmd_watch_o});
    $display("test refusal done");
    // Boot ROM fetch at both ends of its 1k range
    for (int i = 0; i < 2; i++) begin
      rom_fetch_addr_i <= (i == 0) ? 10'h000 : 10'h3FF;
      repeat (2) @(posedge clk_sys_i);
      chk("rom_byte", {24'h0, IMG[(i*1023)*8 +: 8]}, {24'h0, rom_fetch_data_o});
    end
    $display("test boot_rom done");
    // Second reset with the option bit programmed: flash boot
    bus_write(OFF_ADDR_HIGH, 8'h55);
    do_reset(1'b1);
    chk("boot_flash", 32'h0, {31'h0, boot_from_rom_o});
    reg_chk("addr_high_rst", OFF_ADDR_HIGH, 8'h00);
    $display("test flash_boot done");
    end_of_test();
  end
endmodule : ifb_isp_flash_access_tb
